// >>> common/pgsm_consts.svh
`ifndef PGSM_CONSTS_SVH
`define PGSM_CONSTS_SVH

// Register addresses in the management register space
`define PGSM_CTRL_ADDR      8'h03
`define PGSM_STAT_ADDR      8'h04

// Control register fields and reset value
`define PGSM_CTRL_RST       8'h0f
`define PGSM_CTRL_PWR_MSB   3
`define PGSM_CTRL_PWR_LSB   0
`define PGSM_CTRL_MON_BIT   6
`define PGSM_CTRL_SWP_BIT   7

// Status register reset value and filler for unmapped reads
`define PGSM_STAT_RST       8'h00
`define PGSM_RD_NONE        8'h00
`define PGSM_STAT_PAD       4'h0

// Lane counts and route field width
`define PGSM_LANES          4
`define PGSM_SEL_W          2
`define PGSM_LANE_ALL       4'hf
`define PGSM_LANE_NONE      4'h0

`endif

// >>> common/pgsm_pkg.sv
package pgsm_pkg;

    // One bit per lane
    typedef logic [3:0] pgsm_lane_t;

    // Four two-bit input selections, output 0 in the low bits
    typedef logic [7:0] pgsm_route_t;

    // One register byte
    typedef logic [7:0] pgsm_byte_t;

endpackage : pgsm_pkg

// >>> common/pgsm_pwr_if.sv
`timescale 1ns/1ps

interface pgsm_pwr_if;
    logic                 power_up;
    pgsm_pkg::pgsm_lane_t egress_power_bits;
    logic                 input_monitor_enable;
    pgsm_pkg::pgsm_route_t route_sel;
    pgsm_pkg::pgsm_lane_t egress_en;
    pgsm_pkg::pgsm_lane_t ingress_en;

    modport ctrl
    (
        output power_up,
        output egress_power_bits,
        output input_monitor_enable,
        output route_sel,
        input  egress_en,
        input  ingress_en
    );

    modport gate
    (
        input  power_up,
        input  egress_power_bits,
        input  input_monitor_enable,
        input  route_sel,
        output egress_en,
        output ingress_en
    );
endinterface : pgsm_pwr_if

// >>> src/pgsm_gate.sv
`timescale 1ns/1ps
`include "pgsm_consts.svh"

module pgsm_gate
(
    pgsm_pwr_if.gate pwr
);
    // True when some powered output currently selects this input
    function automatic logic pgsm_input_used(pgsm_pkg::pgsm_route_t route,
                                             pgsm_pkg::pgsm_lane_t  out_on,
                                             logic [1:0]            lane);
        logic hit;
        hit = 1'b0;
        for (int o = 0; o < `PGSM_LANES; o++)
        begin
            if (out_on[o] && (route[o*`PGSM_SEL_W +: `PGSM_SEL_W] == lane))
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : pgsm_input_used

    pgsm_pkg::pgsm_lane_t out_on;

    // Every output carries some input, so in power-up all are needed
    // The per-output power bit then decides power-down kills all
    assign out_on = pwr.power_up ? pwr.egress_power_bits : `PGSM_LANE_NONE;
    assign pwr.egress_en = out_on;

    // Inputs run if routed to a live output, or always under monitoring
    always_comb
    begin
        for (int i = 0; i < `PGSM_LANES; i++)
        begin
            pwr.ingress_en[i] = pgsm_input_used(pwr.route_sel, out_on, 2'(i))
                                || pwr.input_monitor_enable;
        end
    end
endmodule : pgsm_gate

// >>> src/pgsm_regs.sv
`timescale 1ns/1ps
`include "pgsm_consts.svh"

// Overview of operation
// - Host reads and writes a control register through the management port.
// - Four output power bits reset to ones; a zero powers that output down.
// - Control bit 6, input monitoring, resets to 0; one turns all input detectors on.
// - While monitoring is on, idle gating never switches off an input or its detector.
// - Control bit 7, software power, resets to 0; zero requests power-down.
// - Power-up when the power-down pin is high or software power is one.
// - Power-down shuts everything except register access; inputs and detectors stay on only while monitoring.
// - Monitoring still powers all inputs and detectors during power-down.
// - In power-up with monitoring off, idle gating switches off every input and output not routed.
// - An output runs only if needed by the route and its power bit is one.
// - An input runs if the route needs it or monitoring is on.
// - Status bits 0-3 read one for a valid signal, zero for open input; read-only.
// - Status bits 7-4 are read-only reserved; host must ignore them.
// - Control register lives at register address 3, read and write.
// - Status register lives at register address 4, read only.
module pgsm_regs
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  hard_power_down_pin_n,
    input  wire pgsm_pkg::pgsm_lane_t  ingress_signal_present,
    input  wire pgsm_pkg::pgsm_route_t route_sel,
    input  wire pgsm_pkg::pgsm_byte_t  reg_addr,
    input  wire logic                  reg_wr,
    input  wire pgsm_pkg::pgsm_byte_t  reg_wdata,
    input  wire logic                  reg_rd,
    output pgsm_pkg::pgsm_byte_t       reg_rdata,
    output logic                       reg_rvalid,
    output logic                       core_power_up,
    output pgsm_pkg::pgsm_lane_t       egress_en,
    output pgsm_pkg::pgsm_lane_t       ingress_en,
    output pgsm_pkg::pgsm_lane_t       detector_en
);
    logic                 rst_meta_q;
    logic                 rst_core_n;
    logic                 pin_n_s;
    pgsm_pkg::pgsm_lane_t present_s;
    pgsm_pkg::pgsm_byte_t ctrl_q;
    pgsm_pkg::pgsm_byte_t ctrl_d;
    pgsm_pkg::pgsm_byte_t rdata_q;
    pgsm_pkg::pgsm_byte_t rdata_d;
    logic                 rvalid_q;
    logic                 rvalid_d;
    logic                 pwr_up_q;
    logic                 pwr_up_d;
    pgsm_pkg::pgsm_lane_t egr_q;
    pgsm_pkg::pgsm_lane_t egr_d;
    pgsm_pkg::pgsm_lane_t ing_q;
    pgsm_pkg::pgsm_lane_t ing_d;
    pgsm_pkg::pgsm_byte_t stat_now;
    logic                 mon_en;

    pgsm_pwr_if pwr ();

    // One address compare for the write path and the checks, so both decode alike
    function automatic logic pgsm_addr_is(pgsm_pkg::pgsm_byte_t addr,
                                          pgsm_pkg::pgsm_byte_t target);
        logic hit;
        hit = (addr == target);
        return hit;
    endfunction : pgsm_addr_is

    // Reset asserts at once and is released through two flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_core_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_core_n <= rst_meta_q;
        end
    end

    // Pin and detector levels arrive from outside the clock domain
    pgsm_sync #(.W(1)) u_pin_sync
    (
        .core_clk   (core_clk),
        .rst_core_n (rst_core_n),
        .async_in   (hard_power_down_pin_n),
        .sync_out   (pin_n_s)
    );

    pgsm_sync #(.W(`PGSM_LANES)) u_present_sync
    (
        .core_clk   (core_clk),
        .rst_core_n (rst_core_n),
        .async_in   (ingress_signal_present),
        .sync_out   (present_s)
    );

    assign mon_en = ctrl_q[`PGSM_CTRL_MON_BIT];

    // Power decision feeds the gating block
    assign pwr.power_up             = pin_n_s | ctrl_q[`PGSM_CTRL_SWP_BIT];
    assign pwr.egress_power_bits    = ctrl_q[`PGSM_CTRL_PWR_MSB:`PGSM_CTRL_PWR_LSB];
    assign pwr.input_monitor_enable = mon_en;
    assign pwr.route_sel            = route_sel;

    pgsm_gate u_gate
    (
        .pwr (pwr.gate)
    );

    // Detectors off read as no signal; they only run with their input
    assign stat_now = {`PGSM_STAT_PAD, present_s & ing_q};

    // Register port: writes to address 3 store all eight bits
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (reg_wr && pgsm_addr_is(reg_addr, `PGSM_CTRL_ADDR))
        begin
            ctrl_d = reg_wdata;
        end
    end

    // Read answer one cycle after the strobe; status ignores writes
    always_comb
    begin
        rvalid_d = reg_rd;
        rdata_d  = rdata_q;
        if (reg_rd)
        begin
            case (reg_addr)
                `PGSM_CTRL_ADDR: rdata_d = ctrl_q;
                `PGSM_STAT_ADDR: rdata_d = stat_now;
                default:         rdata_d = `PGSM_RD_NONE;
            endcase
        end
    end

    // Enables are registered so every output leaves a flop
    // The cost is one cycle of lag between a control write and the lanes
    always_comb
    begin
        pwr_up_d = pwr.power_up;
        egr_d    = pwr.egress_en;
        ing_d    = pwr.ingress_en;
    end

    always_ff @(posedge core_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            ctrl_q   <= `PGSM_CTRL_RST;
            rdata_q  <= `PGSM_RD_NONE;
            rvalid_q <= 1'b0;
            pwr_up_q <= 1'b0;
            egr_q    <= `PGSM_LANE_NONE;
            ing_q    <= `PGSM_LANE_NONE;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            pwr_up_q <= pwr_up_d;
            egr_q    <= egr_d;
            ing_q    <= ing_d;
        end
    end

    // Detectors follow their inputs, so they stay alive while monitoring
    assign reg_rdata     = rdata_q;
    assign reg_rvalid    = rvalid_q;
    assign core_power_up = pwr_up_q;
    assign egress_en     = egr_q;
    assign ingress_en    = ing_q;
    assign detector_en   = ing_q;

    // Checks on the register and power behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_core_n);

    a_ctrl_reset_val: assert property ($rose(rst_core_n) |-> ctrl_q == `PGSM_CTRL_RST)
        else $error("Control register reset value wrong");

    a_ctrl_write_store: assert property (
        reg_wr && reg_addr == `PGSM_CTRL_ADDR |=> ctrl_q == $past(reg_wdata))
        else $error("Control write not stored");

    a_ctrl_read_back: assert property (
        reg_rd && reg_addr == `PGSM_CTRL_ADDR |=> reg_rvalid && reg_rdata == $past(ctrl_q))
        else $error("Control read returned wrong value");

    a_stat_write_none: assert property (
        reg_wr && reg_addr == `PGSM_STAT_ADDR |=> $stable(ctrl_q))
        else $error("Status write disturbed control");

    a_stat_read_val: assert property (
        reg_rd && reg_addr == `PGSM_STAT_ADDR
        |=> reg_rvalid && reg_rdata[3:0] == ($past(present_s) & $past(ing_q)))
        else $error("Status read does not match detectors");

    a_stat_upper_zero: assert property (
        reg_rvalid && $past(reg_addr) == `PGSM_STAT_ADDR |-> reg_rdata[7:4] == 4'h0)
        else $error("Reserved status bits not zero");

    a_power_mode_or: assert property (
        ##1 core_power_up == ($past(pin_n_s) | $past(ctrl_q[`PGSM_CTRL_SWP_BIT])))
        else $error("Power mode not the OR of pin and software bit");

    a_down_outputs_off: assert property (
        !core_power_up |-> egress_en == 4'h0)
        else $error("Output enabled in power-down");

    a_down_inputs_mon: assert property (
        !core_power_up ##0 $past(rst_core_n) |-> ingress_en == {4{$past(mon_en)}})
        else $error("Inputs in power-down do not follow monitoring");

    a_mon_all_inputs: assert property (
        mon_en |=> ingress_en == 4'hf && detector_en == 4'hf)
        else $error("Monitoring did not power all inputs");

    a_egress_needs_bit: assert property (
        ##1 egress_en == ($past(ctrl_q[3:0]) & {4{$past(pwr.power_up)}}))
        else $error("Output enable not gated by power bit");

    a_idle_input_off: assert property (
        core_power_up && egress_en == 4'h0 && !$past(mon_en) |-> ingress_en == 4'h0)
        else $error("Unused input left powered");

    a_sync_delay: assert property (
        $rose(present_s[0]) |-> $past(ingress_signal_present[0], 2))
        else $error("Presence passed without synchronisation");

    // Register port: answer timing, held data and refused addresses
    a_rvalid_follows_rd: assert property (
        ##1 reg_rvalid == $past(reg_rd))
        else $error("Read answer not one cycle after the strobe");

    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("Read data changed without a read");

    a_unmapped_read_zero: assert property (
        reg_rd && !pgsm_addr_is(reg_addr, `PGSM_CTRL_ADDR)
        && !pgsm_addr_is(reg_addr, `PGSM_STAT_ADDR) |=> reg_rdata == `PGSM_RD_NONE)
        else $error("Unmapped read returned data");

    a_ctrl_keeps_value: assert property (
        !(reg_wr && pgsm_addr_is(reg_addr, `PGSM_CTRL_ADDR)) |=> $stable(ctrl_q))
        else $error("Control register changed without a write");

    a_spare_bits_store: assert property (
        reg_wr && pgsm_addr_is(reg_addr, `PGSM_CTRL_ADDR)
        |=> ctrl_q[5:4] == $past(reg_wdata[5:4]))
        else $error("Spare control bits not stored");

    // Power mode: pin and software bit are ORed, the pin through its synchroniser
    a_sw_pin_down: assert property (
        !pin_n_s && !ctrl_q[`PGSM_CTRL_SWP_BIT] |=> !core_power_up)
        else $error("Power-down not entered with pin and software bit low");

    a_pin_forces_up: assert property (
        pin_n_s |=> core_power_up)
        else $error("Power-down pin high did not give power-up");

    a_pin_sync_two: assert property (
        $fell(pin_n_s) |-> !$past(hard_power_down_pin_n, 2))
        else $error("Power-down pin passed without synchronisation");

    // Gating: judged against last cycle's route, since enables are registered
    a_up_power_bits: assert property (
        core_power_up ##0 $past(rst_core_n)
        |-> egress_en == $past(ctrl_q[`PGSM_CTRL_PWR_MSB:`PGSM_CTRL_PWR_LSB]))
        else $error("Output enable in power-up differs from its power bit");

    a_routed_input_on: assert property (
        egress_en[0] |-> ingress_en[$past(route_sel[`PGSM_SEL_W-1:0])])
        else $error("Input routed to a live output left off");

    a_unrouted_input_off: assert property (
        core_power_up && !$past(mon_en) ##0 $past(rst_core_n)
        && !(egress_en[0] && $past(route_sel[1:0]) == 2'h3)
        && !(egress_en[1] && $past(route_sel[3:2]) == 2'h3)
        && !(egress_en[2] && $past(route_sel[5:4]) == 2'h3)
        && !(egress_en[3] && $past(route_sel[7:6]) == 2'h3) |-> !ingress_en[3])
        else $error("Input three powered with no live output selecting it");

    a_down_detect_mon: assert property (
        !core_power_up ##0 $past(rst_core_n) |-> detector_en == {4{$past(mon_en)}})
        else $error("Detectors in power-down do not follow monitoring");

    // Covers for the main scenarios
    c_ctrl_write: cover property (reg_wr && reg_addr == `PGSM_CTRL_ADDR);
    c_stat_read: cover property (reg_rd && reg_addr == `PGSM_STAT_ADDR ##1 reg_rdata[0]);
    c_down_monitor: cover property (!core_power_up && ingress_en == 4'hf);
    c_output_gated: cover property (core_power_up && egress_en != 4'hf);
    c_idle_all_off: cover property (core_power_up && egress_en == 4'h0 && ingress_en == 4'h0);
endmodule : pgsm_regs

// >>> src/pgsm_sync.sv
`timescale 1ns/1ps

module pgsm_sync
#(
    parameter int W = 1
)
(
    input  wire logic         core_clk,
    input  wire logic         rst_core_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            meta_q   <= '0;
            stable_q <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;
endmodule : pgsm_sync

// >>> verification/pgsm_host_model.sv
`timescale 1ns/1ps

// Register host: one strobe at a time, lines inverted once released
module pgsm_host_model
(
    input  wire logic                 core_clk,
    output pgsm_pkg::pgsm_byte_t      reg_addr,
    output logic                      reg_wr,
    output pgsm_pkg::pgsm_byte_t      reg_wdata,
    output logic                      reg_rd,
    input  wire pgsm_pkg::pgsm_byte_t reg_rdata,
    input  wire logic                 reg_rvalid
);
    // Idle bus at time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // Single byte write, held through the taking edge
    task automatic wr(input pgsm_pkg::pgsm_byte_t a, input pgsm_pkg::pgsm_byte_t d);
        @(posedge core_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Single byte read; bounded wait so a silent design cannot hang us
    task automatic rd(input pgsm_pkg::pgsm_byte_t a, output pgsm_pkg::pgsm_byte_t d,
                      output logic ok);
        int n;
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        ok       = 1'b0;
        d        = 8'h00;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (reg_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d  = reg_rdata;
            end
            else
            begin
                @(posedge core_clk);
                #1;
            end
        end
    endtask : rd
endmodule : pgsm_host_model

// >>> verification/test_power_gating_signal_monitor_regs.sv
`timescale 1ns/1ps
`include "pgsm_consts.svh"

module test_power_gating_signal_monitor_regs;
    logic                  core_clk;
    logic                  rst_n;
    logic                  hard_power_down_pin_n;
    pgsm_pkg::pgsm_lane_t  present;
    pgsm_pkg::pgsm_route_t route_sel;
    pgsm_pkg::pgsm_byte_t  reg_addr;
    logic                  reg_wr;
    pgsm_pkg::pgsm_byte_t  reg_wdata;
    logic                  reg_rd;
    pgsm_pkg::pgsm_byte_t  reg_rdata;
    logic                  reg_rvalid;
    logic                  core_power_up;
    pgsm_pkg::pgsm_lane_t  egress_en;
    pgsm_pkg::pgsm_lane_t  ingress_en;
    pgsm_pkg::pgsm_lane_t  detector_en;
    int                    err_count;
    int                    num_checks;

    pgsm_regs u_pgsm_regs (.core_clk(core_clk), .rst_n(rst_n),
        .hard_power_down_pin_n(hard_power_down_pin_n), .ingress_signal_present(present),
        .route_sel(route_sel), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .core_power_up(core_power_up), .egress_en(egress_en), .ingress_en(ingress_en),
        .detector_en(detector_en));

    pgsm_host_model u_pgsm_host_model (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    // Compare tasks, one per kind of result
    task automatic chk_byte(input pgsm_pkg::pgsm_byte_t g, input pgsm_pkg::pgsm_byte_t e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: byte got %h expected %h", $time, g, e);
        end
    endtask : chk_byte

    task automatic chk_lane(input pgsm_pkg::pgsm_lane_t g, input pgsm_pkg::pgsm_lane_t e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: lanes got %b expected %b", $time, g, e);
        end
    endtask : chk_lane

    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: bit got %b expected %b", $time, g, e);
        end
    endtask : chk_bit

    // Enough edges for the slowest path, pin sync plus register
    task automatic settle();
        repeat (6) @(posedge core_clk);
        #1;
    endtask : settle

    // Read, require an answer, compare the bits the host may rely on
    task automatic rd_chk(input pgsm_pkg::pgsm_byte_t a, input pgsm_pkg::pgsm_byte_t m,
                          input pgsm_pkg::pgsm_byte_t e);
        pgsm_pkg::pgsm_byte_t d;
        logic                 ok;
        u_pgsm_host_model.rd(a, d, ok);
        chk_bit(ok, 1'b1);
        if (ok !== 1'b1)
        begin
            stop_test();
        end
        else
        begin
            chk_byte(d & m, e);
            @(posedge core_clk);
            #1;
            chk_bit(reg_rvalid, 1'b0);
        end
    endtask : rd_chk

    // Reset values and idle gating with route zero
    task automatic t_reset();
        rd_chk(`PGSM_CTRL_ADDR, 8'hcf, 8'h0f);
        chk_bit(core_power_up, 1'b1);
        chk_lane(egress_en, 4'hf);
        chk_lane(ingress_en, 4'h1);
        chk_lane(detector_en, 4'h1);
    endtask : t_reset

    // Every pin, software bit and monitor combination
    task automatic t_modes();
        logic pu;
        for (int i = 0; i < 8; i++)
        begin
            hard_power_down_pin_n = i[0];
            u_pgsm_host_model.wr(`PGSM_CTRL_ADDR, {i[1], i[2], 6'h0f});
            settle();
            pu = i[0] | i[1];
            chk_bit(core_power_up, pu);
            chk_lane(egress_en, pu ? 4'hf : 4'h0);
            chk_lane(ingress_en, i[2] ? 4'hf : {3'h0, pu});
            chk_lane(detector_en, i[2] ? 4'hf : {3'h0, pu});
        end
        hard_power_down_pin_n = 1'b1;
    endtask : t_modes

    // Output power bits against straight and reversed routes
    task automatic t_gating();
        route_sel = 8'he4;
        u_pgsm_host_model.wr(`PGSM_CTRL_ADDR, 8'h85);
        settle();
        chk_lane(egress_en, 4'h5);
        chk_lane(ingress_en, 4'h5);
        route_sel = 8'h1b;
        settle();
        chk_lane(ingress_en, 4'ha);
        u_pgsm_host_model.wr(`PGSM_CTRL_ADDR, 8'h80);
        settle();
        chk_bit(core_power_up, 1'b1);
        chk_lane(egress_en, 4'h0);
        chk_lane(ingress_en, 4'h0);
        u_pgsm_host_model.wr(`PGSM_CTRL_ADDR, 8'hc5);
        settle();
        chk_lane(ingress_en, 4'hf);
        chk_lane(egress_en, 4'h5);
    endtask : t_gating

    // Status bits follow detectors; writes and unmapped reads do nothing
    task automatic t_status();
        present = 4'ha;
        settle();
        rd_chk(`PGSM_STAT_ADDR, 8'h0f, 8'h0a);
        u_pgsm_host_model.wr(`PGSM_STAT_ADDR, 8'hff);
        rd_chk(`PGSM_STAT_ADDR, 8'h0f, 8'h0a);
        present = 4'h5;
        settle();
        rd_chk(`PGSM_STAT_ADDR, 8'h0f, 8'h05);
        rd_chk(8'h07, 8'hff, `PGSM_RD_NONE);
        u_pgsm_host_model.wr(8'h07, 8'h00);
        rd_chk(`PGSM_CTRL_ADDR, 8'hcf, 8'hc5);
    endtask : t_status

    // Spare control bits store and read back
    task automatic t_spare();
        u_pgsm_host_model.wr(`PGSM_CTRL_ADDR, 8'hb3);
        rd_chk(`PGSM_CTRL_ADDR, 8'hff, 8'hb3);
    endtask : t_spare

    // Reset in mid-run: outputs drop at once, control returns to its reset value
    task automatic t_reset_again();
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk_bit(core_power_up, 1'b0);
        chk_lane(egress_en, 4'h0);
        chk_lane(ingress_en, 4'h0);
        chk_bit(reg_rvalid, 1'b0);
        chk_byte(reg_rdata, `PGSM_RD_NONE);
        rst_n = 1'b1;
        settle();
        rd_chk(`PGSM_CTRL_ADDR, 8'hcf, 8'h0f);
        chk_lane(egress_en, 4'hf);
        chk_lane(ingress_en, 4'hf);
        rd_chk(`PGSM_STAT_ADDR, 8'h0f, 8'h05);
    endtask : t_reset_again

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Main sequence
    initial
    begin
        core_clk              = 1'b0;
        rst_n                 = 1'b0;
        hard_power_down_pin_n = 1'b1;
        present               = 4'h0;
        route_sel             = 8'h00;
        err_count             = 0;
        num_checks            = 0;
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        settle();
        t_reset();
        t_modes();
        t_gating();
        t_status();
        t_spare();
        t_reset_again();
        stop_test();
    end
endmodule : test_power_gating_signal_monitor_regs
